// ===== hw/iop_pkg.sv
// iop_pkg: constants and types shared by the inhibit and sync pin block
package iop_pkg;

    // =========================================================
    // register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_CMD      = 8'h04;
    localparam logic [7:0] OFS_STAT     = 8'h08;
    localparam logic [7:0] OFS_PWM_PER  = 8'h0C;
    localparam logic [7:0] OFS_PWM_DUTY = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

    // =========================================================
    // control register fields
    localparam int CTL_INV5  = 0;
    localparam int CTL_ROLE5 = 1;
    localparam int CTL_LATCH = 3;
    localparam int CTL_SEL5  = 4;
    localparam int CTL_INV6  = 6;
    localparam int CTL_ROLE6 = 7;
    localparam int CTL_SEL6  = 9;
    localparam int CTRL_W    = 11;
    localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;

    // command register bits
    localparam int CMD_ON  = 0;
    localparam int CMD_OFF = 1;
    localparam int CMD_CLR = 2;

    // status register bits
    localparam int ST_ON   = 0;
    localparam int ST_LOAD = 1;
    localparam int ST_INH  = 2;
    localparam int ST_PROT = 3;
    localparam int ST_LVL5 = 4;
    localparam int ST_LVL6 = 5;

    // interrupt bits
    localparam int IRQ_INH  = 0;
    localparam int IRQ_TRIP = 1;
    localparam int IRQ_SYNC = 2;
    localparam int IRQ_EMIT = 3;
    localparam int IRQ_W    = 4;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

    // pwm
    localparam int PWM_W = 16;
    localparam logic [PWM_W-1:0] PWM_PER_RST  = 16'h00FF;
    localparam logic [PWM_W-1:0] PWM_DUTY_RST = 16'h0080;

    // =========================================================
    // timing
    localparam int CLK_NS       = 4;
    localparam int PULSE_MIN_NS = 30000;
    localparam int PULSE_CYC    = (PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;

    // =========================================================
    // modes
    typedef enum logic [1:0] {ROLE_FUNC, ROLE_IN, ROLE_OUT} iop_role_e;
    typedef enum logic [1:0] {SEL_ONE, SEL_ZERO, SEL_PWM}   iop_sel_e;

endpackage

// ===== hw/iop_pwm_if.sv
// iop_pwm_if: settings and waveform between the pin block and its pwm
`timescale 1ns/1ps
interface iop_pwm_if;
    import iop_pkg::*;
    logic [PWM_W-1:0] period;
    logic [PWM_W-1:0] duty;
    logic             level;

    modport ctrl (output period, output duty, input level);
    modport gen  (input period, input duty, output level);
endinterface

// ===== hw/iop_pwm.sv
// iop_pwm: free running pwm generator with programmable period and duty
`timescale 1ns/1ps
module iop_pwm (
    input  wire logic sys_clk_in,
    input  wire logic rst_n_in,
    iop_pwm_if.gen    pwm
);
    import iop_pkg::*;

    typedef struct packed {
        logic [PWM_W-1:0] cnt;
        logic             level;
    } iop_pwm_state_s;

    iop_pwm_state_s s_reg;
    iop_pwm_state_s s_next;

    // =========================================================
    // counter wraps after period, level high while below duty
    always_comb begin
        s_next = s_reg;
        if (s_reg.cnt >= pwm.period) begin
            s_next.cnt = '0;
        end else begin
            s_next.cnt = s_reg.cnt + 1'b1;
        end
        s_next.level = (s_reg.cnt < pwm.duty);
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pwm.level = s_reg.level;

endmodule

// ===== hw/iop_top.sv
// iop_top: inhibit pin and synchronous turn-on pin control with registers
// Operation
// - each pin's invert option reverses every input and output sense
// - output role drives logic one, logic zero, or configurable pwm
// - non-inverted logic one is a low pin, zero high; inversion swaps
// - idle high inhibit pin in level mode leaves the load untouched
// - level mode: active inhibit forces load off, switch stays on
// - level mode: releasing the inhibit restores the load by itself
// - active level inhibit raises an inhibited indication
// - latched mode: pulse while on turns switch off, sets protection
// - after a trip the switch stays off until cleared and turned on
// - sync pin both accepts pulses and emits pulses
// - a local off-to-on command emits a pulse on the sync pin
// - a sync pulse while the switch is on has no effect
// - a sync pulse while the switch is off and not protected turns it on
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module iop_top #(
    parameter int PULSE_CYCLES = iop_pkg::PULSE_CYC
) (
    input  wire logic                        sys_clk_in,
    input  wire logic                        rst_n_in,
    input  wire logic [iop_pkg::ADDR_W-1:0]  addr_in,
    input  wire logic [iop_pkg::DATA_W-1:0]  wdata_in,
    input  wire logic                        wr_in,
    input  wire logic                        rd_in,
    output logic      [iop_pkg::DATA_W-1:0]  rdata_out,
    input  wire logic                        pin5_in,
    output logic                             pin5_out,
    output logic                             pin5_oe_out,
    input  wire logic                        pin6_in,
    output logic                             pin6_out,
    output logic                             pin6_oe_out,
    output logic                             switch_on_out,
    output logic                             load_enable_out,
    output logic                             inhibited_indication_out,
    output logic                             latched_protection_indication_out,
    output logic                             irq_out
);
    import iop_pkg::*;

    localparam int CNT_W = $clog2(PULSE_CYCLES + 1);

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [PWM_W-1:0]  per;
        logic [PWM_W-1:0]  duty;
        logic [IRQ_W-1:0]  irq_st;
        logic [IRQ_W-1:0]  irq_mask;
        logic              sw_on;
        logic              prot;
        logic              inhibited_indication;
        logic              load_en;
        logic [2:0]        p5_s;
        logic [2:0]        p6_s;
        logic              emitting;
        logic [CNT_W-1:0]  emit_cnt;
        logic              p5_out;
        logic              p5_oe;
        logic              p6_out;
        logic              p6_oe;
        logic [DATA_W-1:0] rdata;
        logic              irq;
    } iop_top_state_s;

    iop_top_state_s s_reg;
    iop_top_state_s s_next;

    iop_pwm_if pwm_bus ();

    iop_role_e role5;
    iop_role_e role6;
    iop_sel_e  sel5;
    iop_sel_e  sel6;
    logic      inv5;
    logic      inv6;
    logic      latch_mode;
    logic      act5;
    logic      act5_prv;
    logic      act6;
    logic      act6_prv;
    logic      edge5;
    logic      edge6;
    logic      func5;
    logic      func6;
    logic      living;
    logic      latch_ev;
    logic      sync_edge;
    logic      sync_on_ev;
    logic      wr_cmd;
    logic      on_cmd;
    logic      off_cmd;
    logic      clr_cmd;
    logic      emit_start;
    logic      rd_irq;

    // =========================================================
    // output value to pin level, polarity applied
    function automatic logic pin_level(iop_sel_e sel, logic inv, logic pw);
        logic val;
        val = 1'b0;
        if (sel == SEL_ONE) begin
            val = 1'b1;
        end else if (sel == SEL_PWM) begin
            val = pw;
        end
        return val ^ ~inv;
    endfunction

    // =========================================================
    // pwm generator shared by both pins
    iop_pwm u_pwm (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .pwm        (pwm_bus.gen)
    );

    assign pwm_bus.period = s_reg.per;
    assign pwm_bus.duty   = s_reg.duty;

    // =========================================================
    // configuration decode
    assign role5      = iop_role_e'(s_reg.ctrl[CTL_ROLE5 +: 2]);
    assign role6      = iop_role_e'(s_reg.ctrl[CTL_ROLE6 +: 2]);
    assign sel5       = iop_sel_e'(s_reg.ctrl[CTL_SEL5 +: 2]);
    assign sel6       = iop_sel_e'(s_reg.ctrl[CTL_SEL6 +: 2]);
    assign inv5       = s_reg.ctrl[CTL_INV5];
    assign inv6       = s_reg.ctrl[CTL_INV6];
    assign latch_mode = s_reg.ctrl[CTL_LATCH];
    assign func5      = (role5 == ROLE_FUNC);
    assign func6      = (role6 == ROLE_FUNC);
    assign living     = func5 & ~latch_mode;

    // =========================================================
    // active sense of synchronised pins; low active unless inverted
    assign act5     = ~(s_reg.p5_s[1] ^ inv5);
    assign act5_prv = ~(s_reg.p5_s[2] ^ inv5);
    assign act6     = ~(s_reg.p6_s[1] ^ inv6);
    assign act6_prv = ~(s_reg.p6_s[2] ^ inv6);
    assign edge5    = act5 & ~act5_prv;
    assign edge6    = act6 & ~act6_prv;

    // =========================================================
    // events; own emitted pulse is not taken as an incoming one
    assign latch_ev   = func5 & latch_mode & edge5 & s_reg.sw_on;
    assign sync_edge  = func6 & edge6 & ~s_reg.emitting;
    assign sync_on_ev = sync_edge & ~s_reg.sw_on & ~s_reg.prot;
    assign wr_cmd     = wr_in && (addr_in == OFS_CMD);
    assign on_cmd     = wr_cmd & wdata_in[CMD_ON] & ~s_reg.sw_on
                        & ~s_reg.prot;
    assign off_cmd    = wr_cmd & wdata_in[CMD_OFF];
    assign clr_cmd    = wr_cmd & wdata_in[CMD_CLR];
    assign emit_start = on_cmd & func6 & ~off_cmd;
    assign rd_irq     = rd_in && (addr_in == OFS_IRQ_STAT);

    // =========================================================
    // next state
    always_comb begin
        s_next = s_reg;

        // two-stage synchronisers plus one history stage
        s_next.p5_s = {s_reg.p5_s[1:0], pin5_in};
        s_next.p6_s = {s_reg.p6_s[1:0], pin6_in};

        // configuration writes
        if (wr_in) begin
            if (addr_in == OFS_CTRL) begin
                s_next.ctrl = wdata_in[CTRL_W-1:0];
            end else if (addr_in == OFS_PWM_PER) begin
                s_next.per = wdata_in[PWM_W-1:0];
            end else if (addr_in == OFS_PWM_DUTY) begin
                s_next.duty = wdata_in[PWM_W-1:0];
            end else if (addr_in == OFS_IRQ_MASK) begin
                s_next.irq_mask = wdata_in[IRQ_W-1:0];
            end
        end

        // on/off switch: turning off wins over turning on
        if (latch_ev || off_cmd) begin
            s_next.sw_on = 1'b0;
        end else if (on_cmd || sync_on_ev) begin
            s_next.sw_on = 1'b1;
        end

        // protection: a trip wins over a clear in the same cycle
        if (latch_ev) begin
            s_next.prot = 1'b1;
        end else if (clr_cmd) begin
            s_next.prot = 1'b0;
        end

        // level inhibit gates the load, switch state untouched
        s_next.inhibited_indication     = living & act5;
        s_next.load_en = s_next.sw_on & ~s_next.inhibited_indication;

        // sync pulse emitter holds the line for the full width
        if (emit_start) begin
            s_next.emitting = 1'b1;
            s_next.emit_cnt = CNT_W'(PULSE_CYCLES - 1);
        end else if (s_reg.emitting) begin
            if (s_reg.emit_cnt == '0) begin
                s_next.emitting = 1'b0;
            end else begin
                s_next.emit_cnt = s_reg.emit_cnt - 1'b1;
            end
        end

        // pin 5 drive
        if (role5 == ROLE_OUT) begin
            s_next.p5_oe  = 1'b1;
            s_next.p5_out = pin_level(sel5, inv5, pwm_bus.level);
        end else begin
            s_next.p5_oe  = 1'b0;
            s_next.p5_out = 1'b0;
        end

        // pin 6 drive: output role or the emitted sync pulse
        if (role6 == ROLE_OUT) begin
            s_next.p6_oe  = 1'b1;
            s_next.p6_out = pin_level(sel6, inv6, pwm_bus.level);
        end else if (func6 && s_next.emitting) begin
            s_next.p6_oe  = 1'b1;
            s_next.p6_out = inv6;
        end else begin
            s_next.p6_oe  = 1'b0;
            s_next.p6_out = 1'b0;
        end

        // sticky events, read clears, a new event wins over the clear
        if (rd_irq) begin
            s_next.irq_st = '0;
        end
        s_next.irq_st[IRQ_INH]  = s_next.irq_st[IRQ_INH]
                                  | (s_next.inhibited_indication & ~s_reg.inhibited_indication);
        s_next.irq_st[IRQ_TRIP] = s_next.irq_st[IRQ_TRIP] | latch_ev;
        s_next.irq_st[IRQ_SYNC] = s_next.irq_st[IRQ_SYNC] | sync_on_ev;
        s_next.irq_st[IRQ_EMIT] = s_next.irq_st[IRQ_EMIT] | emit_start;
        s_next.irq = |(s_next.irq_st & s_next.irq_mask);

        // read data valid only in the cycle after the strobe
        s_next.rdata = '0;
        if (rd_in) begin
            if (addr_in == OFS_CTRL) begin
                s_next.rdata[CTRL_W-1:0] = s_reg.ctrl;
            end else if (addr_in == OFS_STAT) begin
                s_next.rdata[ST_ON]   = s_reg.sw_on;
                s_next.rdata[ST_LOAD] = s_reg.load_en;
                s_next.rdata[ST_INH]  = s_reg.inhibited_indication;
                s_next.rdata[ST_PROT] = s_reg.prot;
                s_next.rdata[ST_LVL5] = s_reg.p5_s[1];
                s_next.rdata[ST_LVL6] = s_reg.p6_s[1];
            end else if (addr_in == OFS_PWM_PER) begin
                s_next.rdata[PWM_W-1:0] = s_reg.per;
            end else if (addr_in == OFS_PWM_DUTY) begin
                s_next.rdata[PWM_W-1:0] = s_reg.duty;
            end else if (addr_in == OFS_IRQ_STAT) begin
                s_next.rdata[IRQ_W-1:0] = s_reg.irq_st;
            end else if (addr_in == OFS_IRQ_MASK) begin
                s_next.rdata[IRQ_W-1:0] = s_reg.irq_mask;
            end
        end
    end

    // =========================================================
    // state register
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            s_reg          <= '0;
            s_reg.ctrl     <= CTRL_RST;
            s_reg.per      <= PWM_PER_RST;
            s_reg.duty     <= PWM_DUTY_RST;
            s_reg.irq_mask <= IRQ_MASK_RST;
            s_reg.p5_s     <= 3'h7;
            s_reg.p6_s     <= 3'h7;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from the state register
    assign rdata_out                         = s_reg.rdata;
    assign pin5_out                          = s_reg.p5_out;
    assign pin5_oe_out                       = s_reg.p5_oe;
    assign pin6_out                          = s_reg.p6_out;
    assign pin6_oe_out                       = s_reg.p6_oe;
    assign switch_on_out                     = s_reg.sw_on;
    assign load_enable_out                   = s_reg.load_en;
    assign inhibited_indication_out          = s_reg.inhibited_indication;
    assign latched_protection_indication_out = s_reg.prot;
    assign irq_out                           = s_reg.irq;

    // =========================================================
    // checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    logic [CNT_W:0] chk_len;

    // counts cycles of the emitted pulse
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            chk_len <= '0;
        end else begin
            // a restarted pulse counts again from its own start
            chk_len <= (s_reg.emitting && !emit_start) ? chk_len + 1'b1 : '0;
        end
    end

    sequence local_on_s;
        emit_start;
    endsequence

    sequence pulse_head_s;
        (pin6_oe_out && pin6_out == $past(inv6)) [*8];
    endsequence

    out_level_one_a: assert property (
        (role5 == ROLE_OUT && sel5 == SEL_ONE && $stable(inv5))
        |=> pin5_oe_out && pin5_out == $past(inv5))
        else $error("pin 5 logic one at wrong level");

    out_pwm_a: assert property (
        (role5 == ROLE_OUT && sel5 == SEL_PWM)
        |=> pin5_out == ($past(pwm_bus.level) ^ ~$past(inv5)))
        else $error("pin 5 does not follow pwm");

    load_gate_a: assert property (
        load_enable_out == (switch_on_out && !inhibited_indication_out))
        else $error("load enable disagrees with switch and inhibit");

    inh_follow_a: assert property (
        (living && !act5) |=> !inhibited_indication_out)
        else $error("inhibit flagged on an idle pin");

    inh_set_a: assert property (
        (living && act5) |=> inhibited_indication_out)
        else $error("active inhibit not flagged");

    inh_restore_a: assert property (
        ($fell(inhibited_indication_out) && switch_on_out)
        |-> load_enable_out)
        else $error("load not restored after inhibit release");

    latch_trip_a: assert property (
        latch_ev |=> !switch_on_out && latched_protection_indication_out)
        else $error("latched inhibit did not trip");

    latch_hold_a: assert property (
        (latched_protection_indication_out && !switch_on_out)
        |=> !switch_on_out)
        else $error("switch came on while protected");

    sync_emit_a: assert property (
        local_on_s |=> pulse_head_s)
        else $error("no sync pulse after local turn on");

    sync_width_a: assert property (
        $fell(s_reg.emitting) |-> chk_len == PULSE_CYCLES)
        else $error("emitted sync pulse has wrong width");

    sync_ignore_a: assert property (
        (sync_edge && switch_on_out && !off_cmd && !latch_ev)
        |=> switch_on_out)
        else $error("sync pulse disturbed an on switch");

    sync_turn_on_a: assert property (
        sync_on_ev && !off_cmd |=> switch_on_out && !pin6_oe_out)
        else $error("sync pulse did not turn switch on");

endmodule

// ===== tb/iop_far_model.sv
// iop_far_model: far instrument on the inhibit and sync-on pins
`timescale 1ns/1ps
module iop_far_model #(
    parameter int PULSE_CYCLES = 20
) (
    input  wire logic sys_clk_in,
    input  wire logic pin5_out_in,
    input  wire logic pin5_oe_in,
    input  wire logic pin6_out_in,
    input  wire logic pin6_oe_in,
    output logic      pin5_wire_out,
    output logic      pin6_wire_out
);
    logic lvl5_reg = 1'b1; // released lines float high through the pull-up
    logic lvl6_reg = 1'b1;
    int   emit_cnt = 0;

    // =========================================================
    // wire level: the device wins while it drives, else the far side
    assign pin5_wire_out = pin5_oe_in ? pin5_out_in : lvl5_reg;
    assign pin6_wire_out = pin6_oe_in ? pin6_out_in : lvl6_reg;

    // count cycles the device itself holds the sync line low
    always @(posedge sys_clk_in) begin
        if (pin6_oe_in && !pin6_wire_out) begin
            emit_cnt <= emit_cnt + 1;
        end
    end

    // change one line right after a clock edge
    task automatic set_level(input int pin, input logic lvl);
        @(posedge sys_clk_in);
        if (pin == 5) begin
            lvl5_reg <= lvl;
        end else begin
            lvl6_reg <= lvl;
        end
    endtask

    // active pulse held for the full minimum width
    task automatic pulse(input int pin, input logic act);
        set_level(pin, act);
        repeat (PULSE_CYCLES - 1) @(posedge sys_clk_in);
        set_level(pin, ~act);
    endtask
endmodule

// ===== tb/tb_top.sv
// tb_top: self-checking bench for the inhibit and sync pin block
`timescale 1ns/1ps
module tb_top;
    import iop_pkg::*;
    localparam int PC = 20; // shortened pulse width

    logic                sys_clk_in = 1'b0;
    logic                rst_n_in   = 1'b0;
    logic [ADDR_W-1:0]   addr_in    = 8'h00;
    logic [DATA_W-1:0]   wdata_in   = 32'h0;
    logic                wr_in      = 1'b0;
    logic                rd_in      = 1'b0;
    logic [DATA_W-1:0]   rdata_out;
    logic                pin5_in, pin5_out, pin5_oe_out;
    logic                pin6_in, pin6_out, pin6_oe_out;
    logic                sw, load, inhibited_indication, prot, irq;
    logic [DATA_W-1:0]   rv;
    int                  failures    = 0;
    int                  comparisons = 0;
    int                  c0, hi, ed;
    logic                lo, o_oe, o_lv;

    always #2 sys_clk_in = ~sys_clk_in;

    iop_top #(.PULSE_CYCLES(PC)) iop_top_inst (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .pin5_in(pin5_in), .pin5_out(pin5_out),
        .pin5_oe_out(pin5_oe_out), .pin6_in(pin6_in), .pin6_out(pin6_out),
        .pin6_oe_out(pin6_oe_out), .switch_on_out(sw),
        .load_enable_out(load), .inhibited_indication_out(inhibited_indication),
        .latched_protection_indication_out(prot), .irq_out(irq));

    iop_far_model #(.PULSE_CYCLES(PC)) iop_far_model_inst (
        .sys_clk_in(sys_clk_in), .pin5_out_in(pin5_out),
        .pin5_oe_in(pin5_oe_out), .pin6_out_in(pin6_out),
        .pin6_oe_in(pin6_oe_out), .pin5_wire_out(pin5_in),
        .pin6_wire_out(pin6_in));

    // =========================================================
    // bus tasks and compares
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        wr_in    <= 1'b1;
        addr_in  <= a;
        wdata_in <= d;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(posedge sys_clk_in);
        rd_in   <= 1'b1;
        addr_in <= a;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        #1 rv = rdata_out; // data stands only in this cycle
    endtask

    task automatic chk_w(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_b(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    // output-role control word for one pin
    function automatic logic [31:0] out_ctl(int p, logic iv, logic [1:0] s);
        if (p == 5) begin
            return (32'(iv) << CTL_INV5) | (32'(ROLE_OUT) << CTL_ROLE5)
                 | (32'(s) << CTL_SEL5);
        end
        return (32'(iv) << CTL_INV6) | (32'(ROLE_OUT) << CTL_ROLE6)
             | (32'(s) << CTL_SEL6);
    endfunction

    task automatic summarize;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        failures++;
        summarize();
    end

    // =========================================================
    // main sequence
    initial begin
        repeat (10) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        cyc(3);
        // reset values and an unmapped place
        rd_reg(OFS_CTRL);
        chk_w("ctrl", 32'(CTRL_RST), rv);
        rd_reg(OFS_PWM_PER);
        chk_w("period", 32'(PWM_PER_RST), rv);
        rd_reg(OFS_PWM_DUTY);
        chk_w("duty", 32'(PWM_DUTY_RST), rv);
        rd_reg(8'h1C);
        chk_w("unmapped", 32'h0, rv);
        // idle inhibit pin, local turn-on emits a sync pulse
        c0 = iop_far_model_inst.emit_cnt;
        wr_reg(OFS_CMD, 32'h1 << CMD_ON);
        chk_b("pin6 oe", 1'b1, pin6_oe_out);
        chk_b("pin6 out", 1'b0, pin6_out);
        cyc(PC + 4);
        chk_b("switch", 1'b1, sw);
        chk_b("load idle pin", 1'b1, load);
        ed = iop_far_model_inst.emit_cnt - c0;
        chk_w("emit width", 32'(PC), 32'(ed));
        rd_reg(OFS_IRQ_STAT);
        chk_w("irq emit", 32'h1 << IRQ_EMIT, rv);
        // level inhibit with the interrupt unmasked
        wr_reg(OFS_IRQ_MASK, 32'h1 << IRQ_INH);
        iop_far_model_inst.set_level(5, 1'b0);
        cyc(5);
        chk_b("load inh", 1'b0, load);
        chk_b("switch inh", 1'b1, sw);
        chk_b("inh flag", 1'b1, inhibited_indication);
        chk_b("irq high", 1'b1, irq);
        // status: on, inhibited, pin 5 low, pin 6 idle high
        rd_reg(OFS_STAT);
        chk_w("status inh", 32'h0000_0025, rv);
        rd_reg(OFS_IRQ_STAT);
        chk_w("irq inh", 32'h1 << IRQ_INH, rv);
        cyc(2);
        chk_b("irq clear", 1'b0, irq);
        iop_far_model_inst.set_level(5, 1'b1);
        cyc(5);
        chk_b("load back", 1'b1, load);
        chk_b("inh gone", 1'b0, inhibited_indication);
        // inverted inhibit: idle high now inhibits
        wr_reg(OFS_IRQ_MASK, 32'h0);
        wr_reg(OFS_CTRL, 32'h1 << CTL_INV5);
        cyc(5);
        chk_b("inv inh", 1'b1, inhibited_indication);
        chk_b("inv load", 1'b0, load);
        iop_far_model_inst.set_level(5, 1'b0);
        cyc(5);
        chk_b("inv release", 1'b1, load);
        iop_far_model_inst.set_level(5, 1'b1);
        wr_reg(OFS_CTRL, 32'h0);
        // latched inhibit trips and needs clear then on
        wr_reg(OFS_CTRL, 32'h1 << CTL_LATCH);
        iop_far_model_inst.pulse(5, 1'b0);
        cyc(5);
        chk_b("trip switch", 1'b0, sw);
        chk_b("trip prot", 1'b1, prot);
        wr_reg(OFS_CMD, 32'h1 << CMD_ON);
        cyc(2);
        chk_b("on refused", 1'b0, sw);
        wr_reg(OFS_CMD, 32'h1 << CMD_CLR);
        cyc(2);
        chk_b("prot clear", 1'b0, prot);
        chk_b("still off", 1'b0, sw);
        wr_reg(OFS_CMD, 32'h1 << CMD_ON);
        chk_b("on again", 1'b1, sw);
        cyc(PC + 4);
        // incoming sync pulses while on and while off
        wr_reg(OFS_CTRL, 32'h0);
        iop_far_model_inst.pulse(6, 1'b0);
        cyc(5);
        chk_b("sync while on", 1'b1, sw);
        wr_reg(OFS_CMD, 32'h1 << CMD_OFF);
        cyc(2);
        chk_b("off", 1'b0, sw);
        c0 = iop_far_model_inst.emit_cnt;
        iop_far_model_inst.pulse(6, 1'b0);
        cyc(5);
        chk_b("sync while off", 1'b1, sw);
        ed = iop_far_model_inst.emit_cnt - c0;
        chk_w("no echo", 32'h0, 32'(ed));
        // inhibit, trip, received and emitted events all stuck
        rd_reg(OFS_IRQ_STAT);
        chk_w("irq all", 32'h0000_000F, rv);
        // input role ignores an incoming pulse
        wr_reg(OFS_CMD, 32'h1 << CMD_OFF);
        wr_reg(OFS_CTRL, 32'(ROLE_IN) << CTL_ROLE6);
        iop_far_model_inst.pulse(6, 1'b0);
        cyc(5);
        chk_b("input role", 1'b0, sw);
        // static output values on both pins, both senses
        for (int p = 5; p <= 6; p++) begin
            for (int k = 0; k < 4; k++) begin
                wr_reg(OFS_CTRL, out_ctl(p, k[0], k[1] ? SEL_ZERO : SEL_ONE));
                cyc(3);
                lo = k[1] ? ~k[0] : k[0];
                o_oe = p == 5 ? pin5_oe_out : pin6_oe_out;
                o_lv = p == 5 ? pin5_out : pin6_out;
                chk_b("out oe", 1'b1, o_oe);
                chk_b("out lvl", lo, o_lv);
            end
        end
        // pwm waveform on pin 5
        wr_reg(OFS_PWM_PER, 32'h9);
        wr_reg(OFS_PWM_DUTY, 32'h3);
        wr_reg(OFS_CTRL, out_ctl(5, 1'b0, SEL_PWM));
        cyc(3);
        hi = 0;
        ed = 0;
        for (int i = 0; i < 60; i++) begin
            lo = pin5_out;
            cyc(1);
            hi += int'(pin5_out);
            ed += int'(pin5_out != lo);
        end
        chk_b("pwm toggles", 1'b1, ed >= 4);
        chk_b("pwm mixed", 1'b1, hi > 0 && hi < 60);
        summarize();
    end
endmodule
